/* File: hdl/dfs_pkg.sv */
// Constants, register map and types for the drive fault supervisor
package dfs_pkg;

   localparam int unsigned DFS_AW          = 8;
   localparam int unsigned DFS_DW          = 32;
   localparam int unsigned DFS_NFLT        = 11;

   // Register byte offsets
   localparam logic [7:0]  DFS_CTRL_OFS    = 8'h00;
   localparam logic [7:0]  DFS_LATCH_OFS   = 8'h04;
   localparam logic [7:0]  DFS_FE_FLT_OFS  = 8'h08;
   localparam logic [7:0]  DFS_FE_WRN_OFS  = 8'h0C;
   localparam logic [7:0]  DFS_POS_WIN_OFS = 8'h10;
   localparam logic [7:0]  DFS_VEL_WIN_OFS = 8'h14;
   localparam logic [7:0]  DFS_TRK_TIM_OFS = 8'h18;
   localparam logic [7:0]  DFS_WIRE_T_OFS  = 8'h1C;
   localparam logic [7:0]  DFS_TEMP_L_OFS  = 8'h20;
   localparam logic [7:0]  DFS_BUS_HI_OFS  = 8'h24;
   localparam logic [7:0]  DFS_BUS_LO_OFS  = 8'h28;
   localparam logic [7:0]  DFS_STATUS_OFS  = 8'h2C;
   localparam logic [7:0]  DFS_FAULT_OFS   = 8'h30;
   localparam logic [7:0]  DFS_ERRLOG_OFS  = 8'h34;

   // Control register fields
   localparam int unsigned DFS_C_FE_EN     = 0;
   localparam int unsigned DFS_C_BRAKE     = 1;
   localparam int unsigned DFS_C_I2T_EN    = 2;
   localparam int unsigned DFS_C_HALL_COR  = 3;
   localparam int unsigned DFS_C_SINE_BL   = 4;
   localparam int unsigned DFS_C_CMD_NET   = 5;
   localparam int unsigned DFS_C_EN_CLR    = 6;
   localparam int unsigned DFS_C_POS_DIG   = 7;
   localparam int unsigned DFS_C_SW_EN     = 8;
   localparam int unsigned DFS_CTRL_W      = 9;

   // Fault bit positions
   localparam int unsigned DFS_F_SHORT     = 0;
   localparam int unsigned DFS_F_AMP_T     = 1;
   localparam int unsigned DFS_F_MOT_T     = 2;
   localparam int unsigned DFS_F_OVER_V    = 3;
   localparam int unsigned DFS_F_UNDER_V   = 4;
   localparam int unsigned DFS_F_FBACK     = 5;
   localparam int unsigned DFS_F_PHASE     = 6;
   localparam int unsigned DFS_F_CMD       = 7;
   localparam int unsigned DFS_F_WIRE      = 8;
   localparam int unsigned DFS_F_OVER_I    = 9;
   localparam int unsigned DFS_F_FOLLOW    = 10;

   // Reset values and latch masks
   localparam logic [8:0]  DFS_CTRL_RST    = 9'h179;
   localparam logic [10:0] DFS_LATCH_RST   = 11'h427;
   localparam logic [10:0] DFS_LATCH_CFG   = 11'h427;
   localparam logic [10:0] DFS_LATCH_FIX   = 11'h200;
   localparam logic [31:0] DFS_THR_RST     = 32'h0000_0000;
   localparam logic [31:0] DFS_FE_FLT_RST  = 32'h0000_1000;
   localparam logic [31:0] DFS_FE_WRN_RST  = 32'h0000_0800;
   localparam logic [31:0] DFS_WIN_RST     = 32'h0000_0100;
   localparam logic [31:0] DFS_TRK_TIM_RST = 32'h0000_0028;
   localparam logic [31:0] DFS_WIRE_T_RST  = 32'h0000_0FA0;
   localparam logic [15:0] DFS_TEMP_L_RST  = 16'h0064;
   localparam logic [15:0] DFS_BUS_HI_RST  = 16'hFFFF;
   localparam logic [15:0] DFS_BUS_LO_RST  = 16'h0000;

   typedef enum logic [2:0] {
      DFS_WT_IDLE = 3'b001,
      DFS_WT_TEST = 3'b010,
      DFS_WT_RUN  = 3'b100
   } dfs_wire_t;

endpackage : dfs_pkg

/* File: hdl/dfs_supervisor.sv */
// Drive fault supervisor: fault latching, following error and tracking windows
`timescale 1ns/1ps
module dfs_supervisor (
   input  wire logic                       core_clk,
   input  wire logic                       reset,
   input  wire logic [dfs_pkg::DFS_AW-1:0] reg_addr,
   input  wire logic [dfs_pkg::DFS_DW-1:0] reg_wdata,
   input  wire logic                       reg_write,
   input  wire logic                       reg_read,
   output logic      [dfs_pkg::DFS_DW-1:0] reg_rdata,
   input  wire logic                       short_out_out,
   input  wire logic                       short_out_gnd,
   input  wire logic                       bridge_fault,
   input  wire logic [15:0]                amp_temp,
   input  wire logic                       motor_tswitch_hot,
   input  wire logic [15:0]                bus_voltage,
   input  wire logic                       enc_supply_oc,
   input  wire logic                       enc_missing,
   input  wire logic                       fb_out_of_tol,
   input  wire logic                       phase_mismatch,
   input  wire logic                       pwm_cmd_ok,
   input  wire logic                       net_cmd_ok,
   input  wire logic                       motor_current_seen,
   input  wire logic                       i2t_limit_reached,
   input  wire logic signed [31:0]         traj_pos,
   input  wire logic signed [31:0]         actual_pos,
   input  wire logic signed [31:0]         vel_cmd,
   input  wire logic signed [31:0]         actual_vel,
   input  wire logic                       enable_in,
   input  wire logic                       new_traj_cmd,
   output logic                            pwm_enable,
   output logic                            brake_release,
   output logic                            vel_stop_hold,
   output logic                            fe_warning,
   output logic                            fe_fault,
   output logic                            track_pos,
   output logic                            track_vel,
   output logic                            fault_any
);
   import dfs_pkg::*;

   // Magnitude of a signed error, saturating the most negative value
   function automatic logic [31:0] dfs_mag(input logic signed [31:0] v);
      logic [31:0] m;
      m = v[31] ? 32'(-v) : 32'(v);
      if (m[31]) begin
         m = 32'h7FFF_FFFF;
      end
      return m;
   endfunction : dfs_mag

   logic [DFS_CTRL_W-1:0] ctrl;
   logic [DFS_NFLT-1:0]   latch_cfg;
   logic [31:0]           fe_flt_thr;
   logic [31:0]           fe_wrn_thr;
   logic [31:0]           pos_win;
   logic [31:0]           vel_win;
   logic [31:0]           trk_time;
   logic [31:0]           wire_time;
   logic [15:0]           temp_lim;
   logic [15:0]           bus_hi;
   logic [15:0]           bus_lo;
   logic [DFS_NFLT-1:0]   err_log;
   logic [DFS_NFLT-1:0]   flt_latched;
   logic [DFS_NFLT-1:0]   flt_prev;
   logic [DFS_NFLT-1:0]   cond;
   logic [DFS_NFLT-1:0]   latch_eff;
   logic [DFS_NFLT-1:0]   flt_active;
   logic                  host_clear;
   logic                  log_wr;
   logic                  drv_en;
   logic                  drv_en_q;
   logic                  en_rise;
   logic                  latched_clear;
   logic signed [31:0]    pos_err;
   logic signed [31:0]    vel_err;
   logic [31:0]           pos_mag;
   logic [31:0]           vel_mag;
   logic                  fe_reach;
   logic                  fe_nl;
   logic                  fe_nl_clear;
   logic                  wire_cond;
   logic                  wire_ok;
   logic                  wire_seen;
   logic [31:0]           wire_cnt;
   dfs_wire_t             wire_st;
   logic [31:0]           pos_in_cnt;
   logic [31:0]           vel_in_cnt;
   logic                  other_fault;
   logic                  next_pwm_enable;
   logic                  next_brake_release;
   logic [31:0]           status_word;

   assign drv_en  = enable_in & ctrl[DFS_C_SW_EN];
   assign en_rise = drv_en & ~drv_en_q;
   assign host_clear = reg_write && (reg_addr == DFS_FAULT_OFS);
   assign log_wr     = reg_write && (reg_addr == DFS_ERRLOG_OFS);
   assign latched_clear = host_clear | (en_rise & ctrl[DFS_C_EN_CLR]);

   // Register writes
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl       <= DFS_CTRL_RST;
         latch_cfg  <= DFS_LATCH_RST;
         fe_flt_thr <= DFS_FE_FLT_RST;
         fe_wrn_thr <= DFS_FE_WRN_RST;
         pos_win    <= DFS_WIN_RST;
         vel_win    <= DFS_WIN_RST;
         trk_time   <= DFS_TRK_TIM_RST;
         wire_time  <= DFS_WIRE_T_RST;
         temp_lim   <= DFS_TEMP_L_RST;
         bus_hi     <= DFS_BUS_HI_RST;
         bus_lo     <= DFS_BUS_LO_RST;
      end else if (reg_write) begin
         case (reg_addr)
            DFS_CTRL_OFS:    ctrl       <= reg_wdata[DFS_CTRL_W-1:0];
            DFS_LATCH_OFS:   latch_cfg  <= reg_wdata[DFS_NFLT-1:0];
            DFS_FE_FLT_OFS:  fe_flt_thr <= reg_wdata;
            DFS_FE_WRN_OFS:  fe_wrn_thr <= reg_wdata;
            DFS_POS_WIN_OFS: pos_win    <= reg_wdata;
            DFS_VEL_WIN_OFS: vel_win    <= reg_wdata;
            DFS_TRK_TIM_OFS: trk_time   <= reg_wdata;
            DFS_WIRE_T_OFS:  wire_time  <= reg_wdata;
            DFS_TEMP_L_OFS:  temp_lim   <= reg_wdata[15:0];
            DFS_BUS_HI_OFS:  bus_hi     <= reg_wdata[15:0];
            DFS_BUS_LO_OFS:  bus_lo     <= reg_wdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // Over-current latches whatever the register says
   assign latch_eff = (latch_cfg & DFS_LATCH_CFG) | DFS_LATCH_FIX;

   // Errors and threshold tests
   assign pos_err  = traj_pos - actual_pos;
   assign vel_err  = vel_cmd - actual_vel;
   assign pos_mag  = dfs_mag(pos_err);
   assign vel_mag  = dfs_mag(vel_err);
   assign fe_reach = ctrl[DFS_C_FE_EN] && (pos_mag >= fe_flt_thr);

   // Raw fault conditions
   always_comb begin
      cond = '0;
      cond[DFS_F_SHORT]   = short_out_out | short_out_gnd | bridge_fault;
      cond[DFS_F_AMP_T]   = amp_temp > temp_lim;
      cond[DFS_F_MOT_T]   = motor_tswitch_hot;
      cond[DFS_F_OVER_V]  = bus_voltage > bus_hi;
      cond[DFS_F_UNDER_V] = bus_voltage < bus_lo;
      cond[DFS_F_FBACK]   = enc_supply_oc | enc_missing | fb_out_of_tol;
      cond[DFS_F_PHASE]   = phase_mismatch & ctrl[DFS_C_SINE_BL] & ctrl[DFS_C_HALL_COR];
      cond[DFS_F_CMD]     = ctrl[DFS_C_CMD_NET] ? ~net_cmd_ok : ~pwm_cmd_ok;
      cond[DFS_F_WIRE]    = wire_cond;
      cond[DFS_F_OVER_I]  = i2t_limit_reached & ctrl[DFS_C_I2T_EN];
      cond[DFS_F_FOLLOW]  = fe_reach;
   end

   // Latched fault flags: set wins, clear needs a corrected condition
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flt_latched <= '0;
      end else begin
         for (int i = 0; i < DFS_NFLT; i++) begin
            if (cond[i] && latch_eff[i]) begin
               flt_latched[i] <= 1'b1;
            end else if (latched_clear) begin
               flt_latched[i] <= 1'b0;
            end
         end
      end
   end

   // Non-latched following fault holds until a new command, or until an enable cycle when DFS_C_POS_DIG is set
   assign fe_nl_clear = ctrl[DFS_C_POS_DIG] ? en_rise : new_traj_cmd;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         fe_nl <= 1'b0;
      end else if (fe_reach && !latch_eff[DFS_F_FOLLOW]) begin
         fe_nl <= 1'b1;
      end else if (fe_nl_clear || latch_eff[DFS_F_FOLLOW]) begin
         fe_nl <= 1'b0;
      end
   end

   // Active faults; non-latched ones other than the following fault drop with their cause
   always_comb begin
      flt_active = (cond & ~latch_eff) | flt_latched;
      flt_active[DFS_F_FOLLOW] = flt_latched[DFS_F_FOLLOW] | fe_nl;
   end

   // Error log records each new fault until software clears it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         flt_prev <= '0;
         err_log  <= '0;
      end else begin
         flt_prev <= flt_active;
         for (int i = 0; i < DFS_NFLT; i++) begin
            if (flt_active[i] && !flt_prev[i]) begin
               err_log[i] <= 1'b1;
            end else if (log_wr && reg_wdata[i]) begin
               err_log[i] <= 1'b0;
            end
         end
      end
   end

   // Wiring test: PWM on, brake held, look for current before release
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wire_st   <= DFS_WT_IDLE;
         wire_cnt  <= '0;
         wire_seen <= 1'b0;
         wire_cond <= 1'b0;
         wire_ok   <= 1'b0;
      end else begin
         case (wire_st)
            DFS_WT_IDLE: begin
               wire_ok <= 1'b0;
               if (en_rise) begin
                  if (ctrl[DFS_C_BRAKE]) begin
                     wire_st   <= DFS_WT_TEST;
                     wire_cnt  <= '0;
                     wire_seen <= 1'b0;
                  end else begin
                     wire_st <= DFS_WT_RUN;
                     wire_ok <= 1'b1;
                  end
               end
            end
            DFS_WT_TEST: begin
               wire_cnt  <= wire_cnt + 32'h0000_0001;
               wire_seen <= wire_seen | motor_current_seen;
               if (!drv_en) begin
                  wire_st <= DFS_WT_IDLE;
               end else if (wire_cnt >= wire_time) begin
                  wire_st   <= DFS_WT_RUN;
                  wire_cond <= ~(wire_seen | motor_current_seen);
                  wire_ok   <= wire_seen | motor_current_seen;
               end
            end
            DFS_WT_RUN: begin
               if (!drv_en) begin
                  wire_st <= DFS_WT_IDLE;
                  wire_ok <= 1'b0;
               end
            end
            default: begin
               wire_st <= DFS_WT_IDLE;
            end
         endcase
      end
   end

   // Enable edge tracking
   always_ff @(posedge core_clk) begin
      if (reset) begin
         drv_en_q <= 1'b0;
      end else begin
         drv_en_q <= drv_en;
      end
   end

   // Following error warning and fault status
   always_ff @(posedge core_clk) begin
      if (reset) begin
         fe_warning <= 1'b0;
         fe_fault   <= 1'b0;
      end else begin
         fe_warning <= pos_mag >= fe_wrn_thr;
         fe_fault   <= flt_active[DFS_F_FOLLOW];
      end
   end

   // Tracking windows; a plain counter avoids a long timer per window
   always_ff @(posedge core_clk) begin
      if (reset) begin
         track_pos  <= 1'b0;
         track_vel  <= 1'b0;
         pos_in_cnt <= '0;
         vel_in_cnt <= '0;
      end else begin
         if (pos_mag > pos_win) begin
            track_pos  <= 1'b1;
            pos_in_cnt <= '0;
         end else if (track_pos) begin
            if (pos_in_cnt + 32'h0000_0001 >= trk_time) begin
               track_pos <= 1'b0;
            end
            pos_in_cnt <= pos_in_cnt + 32'h0000_0001;
         end
         if (vel_mag > vel_win) begin
            track_vel  <= 1'b1;
            vel_in_cnt <= '0;
         end else if (track_vel) begin
            if (vel_in_cnt + 32'h0000_0001 >= trk_time) begin
               track_vel <= 1'b0;
            end
            vel_in_cnt <= vel_in_cnt + 32'h0000_0001;
         end
      end
   end

   // Output stage control
   assign other_fault = |(flt_active & ~(DFS_NFLT'(1) << DFS_F_FOLLOW));
   always_comb begin
      next_pwm_enable    = drv_en && !other_fault && !flt_latched[DFS_F_FOLLOW];
      next_brake_release = next_pwm_enable && wire_ok && (wire_st == DFS_WT_RUN);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         pwm_enable    <= 1'b0;
         brake_release <= 1'b0;
         vel_stop_hold <= 1'b0;
         fault_any     <= 1'b0;
      end else begin
         pwm_enable    <= next_pwm_enable;
         brake_release <= next_brake_release;
         vel_stop_hold <= fe_nl;
         fault_any     <= |flt_active;
      end
   end

   assign status_word = {24'h00_0000, (wire_st == DFS_WT_TEST), vel_stop_hold, brake_release,
                         pwm_enable, track_vel, track_pos, fe_fault, fe_warning};

   // Read data, valid in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge core_clk) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            DFS_CTRL_OFS:    reg_rdata <= 32'(ctrl);
            DFS_LATCH_OFS:   reg_rdata <= 32'(latch_cfg);
            DFS_FE_FLT_OFS:  reg_rdata <= fe_flt_thr;
            DFS_FE_WRN_OFS:  reg_rdata <= fe_wrn_thr;
            DFS_POS_WIN_OFS: reg_rdata <= pos_win;
            DFS_VEL_WIN_OFS: reg_rdata <= vel_win;
            DFS_TRK_TIM_OFS: reg_rdata <= trk_time;
            DFS_WIRE_T_OFS:  reg_rdata <= wire_time;
            DFS_TEMP_L_OFS:  reg_rdata <= 32'(temp_lim);
            DFS_BUS_HI_OFS:  reg_rdata <= 32'(bus_hi);
            DFS_BUS_LO_OFS:  reg_rdata <= 32'(bus_lo);
            DFS_STATUS_OFS:  reg_rdata <= status_word;
            DFS_FAULT_OFS:   reg_rdata <= 32'(flt_active);
            DFS_ERRLOG_OFS:  reg_rdata <= 32'(err_log);
            default:         reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule : dfs_supervisor

/* File: testbench/dfs_supervisor_sva.sv */
// Port-level assertions for the drive fault supervisor
`timescale 1ns/1ps
module dfs_supervisor_sva (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic short_out_out,
   input wire logic short_out_gnd,
   input wire logic bridge_fault,
   input wire logic motor_tswitch_hot,
   input wire logic enc_supply_oc,
   input wire logic enc_missing,
   input wire logic fb_out_of_tol,
   input wire logic pwm_cmd_ok,
   input wire logic net_cmd_ok,
   input wire logic enable_in,
   input wire logic pwm_enable,
   input wire logic brake_release,
   input wire logic vel_stop_hold,
   input wire logic fe_warning,
   input wire logic fe_fault,
   input wire logic track_pos,
   input wire logic fault_any
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   short_flt_a: assert property ((short_out_out || short_out_gnd || bridge_fault)
      |-> ##[1:2] fault_any && !pwm_enable)
      else $error("short did not stop the output stage");
   fback_flt_a: assert property ((enc_supply_oc || enc_missing || fb_out_of_tol)
      |-> ##[1:2] fault_any && !pwm_enable)
      else $error("feedback problem did not fault");
   mot_temp_a: assert property (motor_tswitch_hot |-> ##[1:2] fault_any && !pwm_enable && !brake_release)
      else $error("motor switch did not fault");
   cmd_loss_a: assert property (!pwm_cmd_ok && !net_cmd_ok |=> fault_any)
      else $error("command loss did not fault");
   fe_hold_a: assert property (vel_stop_hold |-> fe_fault && fault_any)
      else $error("stop hold without following fault");
   fe_latch_a: assert property (fe_fault && !vel_stop_hold |-> !pwm_enable && !brake_release)
      else $error("latched following fault left stage on");
   other_pwm_a: assert property (fault_any && !fe_fault |-> !pwm_enable)
      else $error("fault left stage on");
   en_gate_a: assert property (pwm_enable |-> $past(enable_in))
      else $error("stage on without enable");
   reset_out_a: assert property (disable iff (1'b0) reset |=> !pwm_enable && !fault_any && !fe_fault && !brake_release)
      else $error("outputs active after reset");
   cover property (vel_stop_hold);
   cover property (fe_fault && !vel_stop_hold);
   cover property ($fell(track_pos));
   cover property (fe_warning && !fe_fault);
endmodule : dfs_supervisor_sva

bind dfs_supervisor dfs_supervisor_sva dfs_supervisor_sva_inst (.core_clk, .reset, .short_out_out, .short_out_gnd,
   .bridge_fault, .motor_tswitch_hot, .enc_supply_oc, .enc_missing, .fb_out_of_tol, .pwm_cmd_ok, .net_cmd_ok,
   .enable_in, .pwm_enable, .brake_release, .vel_stop_hold, .fe_warning, .fe_fault, .track_pos, .fault_any);

/* File: testbench/dfs_host.sv */
// Host model: register bus master and host commands
`timescale 1ns/1ps
module dfs_host (
   input  wire logic                       core_clk,
   output logic      [dfs_pkg::DFS_AW-1:0] reg_addr,
   output logic      [dfs_pkg::DFS_DW-1:0] reg_wdata,
   output logic                            reg_write,
   output logic                            reg_read,
   input  wire logic [dfs_pkg::DFS_DW-1:0] reg_rdata,
   output logic                            new_traj_cmd
);
   import dfs_pkg::*;
   initial begin
      reg_addr     = '0;
      reg_wdata    = '0;
      reg_write    = 1'b0;
      reg_read     = 1'b0;
      new_traj_cmd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      reg_wdata <= ~v;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd
   // Any write to the fault register is a clear
   task automatic clr();
      wr(DFS_FAULT_OFS, 32'h0);
   endtask : clr
   // Software disable then enable
   task automatic sw_cycle(input logic [31:0] c);
      wr(DFS_CTRL_OFS, c & ~32'h100);
      wr(DFS_CTRL_OFS, c | 32'h100);
   endtask : sw_cycle
   task automatic traj();
      @(posedge core_clk);
      new_traj_cmd <= 1'b1;
      @(posedge core_clk);
      new_traj_cmd <= 1'b0;
   endtask : traj
endmodule : dfs_host

/* File: testbench/dfs_supervisor_tb.sv */
// Self-checking testbench for the drive fault supervisor
`timescale 1ns/1ps
module dfs_supervisor_tb;
   import dfs_pkg::*;
   typedef struct {
      logic signed [31:0] perr;
      logic signed [31:0] verr;
      logic [2:0]         exp;
   } dfs_row_t;
   logic               core_clk, reset, reg_write, reg_read, new_traj_cmd, motor_current_seen, enable_in;
   logic [7:0]         reg_addr;
   logic [31:0]        reg_wdata, reg_rdata, d;
   logic [8:0]         cond;
   logic [15:0]        amp_temp, bus_voltage;
   logic signed [31:0] traj_pos, actual_pos, vel_cmd, actual_vel;
   logic               pwm_enable, brake_release, vel_stop_hold, fe_warning, fe_fault, track_pos, track_vel, fault_any;
   int                 err_total, total_checks;
   int                 fb [9];
   dfs_row_t           rows [8];
   logic [7:0]         ra [12];
   logic [31:0]        rv [12];
   logic [32:0]        bt [5];
   dfs_host dfs_host_inst (.core_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .new_traj_cmd);
   dfs_supervisor dfs_supervisor_inst (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .short_out_out(cond[0]), .short_out_gnd(cond[1]), .bridge_fault(cond[2]), .amp_temp,
      .motor_tswitch_hot(cond[3]), .bus_voltage, .enc_supply_oc(cond[4]), .enc_missing(cond[5]),
      .fb_out_of_tol(cond[6]), .phase_mismatch(cond[7]), .pwm_cmd_ok(~cond[8]), .net_cmd_ok(~cond[8]),
      .motor_current_seen, .i2t_limit_reached(1'b0), .traj_pos, .actual_pos, .vel_cmd, .actual_vel,
      .enable_in, .new_traj_cmd, .pwm_enable, .brake_release, .vel_stop_hold, .fe_warning, .fe_fault,
      .track_pos, .track_vel, .fault_any);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   // Watchdog, about twelve times the run
   initial begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      test_done();
   end
   initial begin
      reset = 1'b1; cond = '0; amp_temp = 16'h0020; bus_voltage = 16'h8000; motor_current_seen = 1'b0;
      enable_in = 1'b1; traj_pos = 32'sh4000; actual_pos = 32'sh4000; vel_cmd = '0; actual_vel = '0;
      err_total = 0; total_checks = 0;
      fb = '{0, 0, 0, 2, 5, 5, 5, 6, 7};
      rows = '{'{32'sh0, 32'sh0, 3'b000}, '{32'sh100, -32'sh100, 3'b000}, '{32'sh101, 32'sh101, 3'b011},
               '{32'sh7FF, -32'sh7FFF_FFFF, 3'b011}, '{32'sh800, 32'sh0, 3'b110}, '{-32'sh800, 32'sh0, 3'b110},
               '{-32'sh7FF, 32'sh0, 3'b010}, '{32'sh0, 32'sh0, 3'b000}};
      ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h3C};
      rv = '{32'h179, 32'h427, 32'h1000, 32'h800, 32'h100, 32'h100, 32'h28, 32'hFA0, 32'h64, 32'hFFFF, 32'h0, 32'h0};
      bt = '{33'h0_9000_0064, 33'h1_9001_0064, 33'h0_7000_0064, 33'h1_6FFF_0064, 33'h1_8000_0065};
      step(4);
      chk("rst_out", 2'b00, {pwm_enable, fault_any});
      @(posedge core_clk);
      reset <= 1'b0;
      foreach (ra[i]) begin
         dfs_host_inst.rd(ra[i], d);
         chk("reg_rst", rv[i], d);
      end
      dfs_host_inst.wr(DFS_TRK_TIM_OFS, 32'h4);
      step(2);
      chk("run", 2'b11, {pwm_enable, brake_release});
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge core_clk);
         traj_pos <= 32'sh4000 + rows[i].perr;
         vel_cmd <= rows[i].verr;
         step(8);
         chk("warn", rows[i].exp[2], fe_warning);
         chk("tpos", rows[i].exp[1], track_pos);
         chk("tvel", rows[i].exp[0], track_vel);
         chk("no_vel_fault", 0, fault_any);
         dfs_host_inst.rd(DFS_STATUS_OFS, d);
         chk("status", {1'b1, rows[i].exp[0], rows[i].exp[1], 1'b0, rows[i].exp[2]}, d[4:0]);
      end
      $display("test rows done");
      @(posedge core_clk);
      traj_pos <= 32'sh4200;
      step(3);
      chk("trk_set", 1, track_pos);
      @(posedge core_clk);
      traj_pos <= 32'sh4000;
      step(2);
      chk("trk_hold", 1, track_pos);
      step(6);
      chk("trk_clr", 0, track_pos);
      $display("test tracking done");
      dfs_host_inst.wr(DFS_LATCH_OFS, 32'h027);
      @(posedge core_clk);
      traj_pos <= 32'sh5000;
      step(3);
      chk("nl_fe", 3'b111, {fe_fault, vel_stop_hold, pwm_enable});
      dfs_host_inst.rd(DFS_ERRLOG_OFS, d);
      chk("fe_log", 1, d[10]);
      @(posedge core_clk);
      traj_pos <= 32'sh4000;
      step(3);
      chk("nl_fe_stay", 1, fe_fault);
      dfs_host_inst.traj();
      step(3);
      chk("nl_fe_clr", 2'b01, {fe_fault, pwm_enable});
      dfs_host_inst.wr(DFS_CTRL_OFS, 32'h1F9);
      traj_pos <= 32'sh5000;
      step(1);
      traj_pos <= 32'sh4000;
      dfs_host_inst.traj();
      step(3);
      chk("dig_stay", 1, fe_fault);
      dfs_host_inst.sw_cycle(32'h1F9);
      step(3);
      chk("dig_clr", 0, fe_fault);
      dfs_host_inst.wr(DFS_CTRL_OFS, 32'h178);
      @(posedge core_clk);
      traj_pos <= 32'sh5000;
      step(3);
      chk("fe_off", 2'b01, {fe_fault, fe_warning});
      @(posedge core_clk);
      traj_pos <= 32'sh4000;
      dfs_host_inst.wr(DFS_CTRL_OFS, 32'h179);
      dfs_host_inst.wr(DFS_LATCH_OFS, 32'h427);
      @(posedge core_clk);
      traj_pos <= 32'sh3000;
      step(3);
      chk("l_fe", 4'b1000, {fe_fault, vel_stop_hold, pwm_enable, brake_release});
      @(posedge core_clk);
      traj_pos <= 32'sh4000;
      step(4);
      chk("l_fe_stay", 1, fe_fault);
      dfs_host_inst.clr();
      step(4);
      chk("l_fe_clr", 3'b011, {fe_fault, pwm_enable, brake_release});
      $display("test following done");
      @(posedge core_clk);
      cond <= 9'h002;
      step(3);
      chk("sc_on", 1, fault_any);
      dfs_host_inst.clr();
      step(3);
      chk("sc_refused", 1, fault_any);
      @(posedge core_clk);
      cond <= '0;
      step(4);
      chk("sc_latched", 1, fault_any);
      dfs_host_inst.sw_cycle(32'h179);
      step(4);
      chk("sc_clr", 2'b01, {fault_any, pwm_enable});
      $display("test latched done");
      dfs_host_inst.wr(DFS_LATCH_OFS, 32'h0);
      for (int i = 0; i < 9; i++) begin
         @(posedge core_clk);
         cond <= 9'h1 << i;
         step(3);
         chk("nl_on", 2'b10, {fault_any, pwm_enable});
         dfs_host_inst.rd(DFS_FAULT_OFS, d);
         chk("nl_bit", 32'h1 << fb[i], d);
         @(posedge core_clk);
         cond <= '0;
         step(4);
         chk("nl_off", 2'b01, {fault_any, pwm_enable});
      end
      dfs_host_inst.wr(DFS_BUS_HI_OFS, 32'h9000);
      dfs_host_inst.wr(DFS_BUS_LO_OFS, 32'h7000);
      foreach (bt[i]) begin
         @(posedge core_clk);
         {bus_voltage, amp_temp} <= bt[i][31:0];
         step(3);
         chk("lvl_on", bt[i][32], fault_any);
         @(posedge core_clk);
         {bus_voltage, amp_temp} <= 32'h8000_0020;
         step(4);
         chk("lvl_off", 0, fault_any);
      end
      dfs_host_inst.wr(DFS_CTRL_OFS, 32'h171);
      @(posedge core_clk);
      cond <= 9'h080;
      step(3);
      chk("phase_off", 0, fault_any);
      @(posedge core_clk);
      cond <= '0;
      $display("test self clearing done");
      dfs_host_inst.wr(DFS_WIRE_T_OFS, 32'h4);
      dfs_host_inst.sw_cycle(32'h17B);
      step(12);
      chk("wire_flt", 2'b01, {brake_release, fault_any});
      @(posedge core_clk);
      motor_current_seen <= 1'b1;
      dfs_host_inst.sw_cycle(32'h17B);
      step(12);
      chk("wire_ok", 2'b10, {brake_release, fault_any});
      $display("test wiring done");
      test_done();
   end
endmodule : dfs_supervisor_tb
